// file: hdl/rcd_device.sv
// rcd_device: double-buffered weekday, month and year counters.
// assumes: host drives the register port on this clock; sys_rst is the
// rtc supply undervoltage reset.
// Behaviour
// - writes held, loaded on write-update request
// - read copies refresh only on read-update
// - weekday is seven-bit one-hot
// - bit zero Sunday up to bit six Saturday
// - binary month holds one to twelve
// - bcd month tens zero/one, units 0-9
// - bcd month between one and twelve
// - binary year holds zero to ninety-nine
// - bcd year two decimal digits
// - one format bit: binary or bcd
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module rcd_device (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    rcd_reg_if.device bus,
    output logic      bcd_mode,
    output logic      field_error
);
    import rcd_pkg::*;

    // holding buffer: host writes land here until a write-update
    logic [7:0] hw_q;
    logic [7:0] hw_d;
    logic [7:0] hm_q;
    logic [7:0] hm_d;
    logic [7:0] hy_q;
    logic [7:0] hy_d;

    // read snapshot: what the host sees between read-updates
    logic [7:0] rw_q;
    logic [7:0] rw_d;
    logic [7:0] rm_q;
    logic [7:0] rm_d;
    logic [7:0] ry_q;
    logic [7:0] ry_d;

    // running counters, read data, format bit and error flag
    logic [7:0] cw_q;
    logic [7:0] cw_d;
    logic [7:0] cm_q;
    logic [7:0] cm_d;
    logic [7:0] cy_q;
    logic [7:0] cy_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       bcd_q;
    logic       bcd_d;
    logic       err_q;
    logic       err_d;

    // decoded control strobes, year carry and field checks
    logic       ctl_wr;
    logic       day_tick;
    logic       wr_upd;
    logic       rd_upd;
    logic       wrap_y;
    logic       wday_bad;
    logic       month_bad;
    logic       year_bad;

    assign bus.rdata   = rdata_q;
    assign bcd_mode    = bcd_q;
    assign field_error = err_q;

    function automatic logic [7:0] inc(input logic [7:0] v, input logic bcd);
        // bcd units roll at nine into the tens digit
        if (bcd && v[3:0] == 4'h9) begin
            inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            inc = v + 8'h01;
        end
    endfunction

    function automatic logic month_ok(input logic [7:0] v, input logic bcd);
        if (bcd) begin
            month_ok = v[7:5] == 3'h0 && v[3:0] <= 4'h9 && v != 8'h00
                       && v <= MONTH_LAST_BCD;
        end else begin
            month_ok = v != 8'h00 && v <= MONTH_LAST_BIN;
        end
    endfunction

    function automatic logic year_ok(input logic [7:0] v, input logic bcd);
        if (bcd) begin
            year_ok = v[7:4] <= 4'h9 && v[3:0] <= 4'h9;
        end else begin
            year_ok = v <= YEAR_LAST_BIN;
        end
    endfunction

    assign ctl_wr   = bus.wr && bus.addr == OFS_UPDATE;
    assign day_tick = ctl_wr && bus.wdata[BIT_DAY_TICK];
    assign wr_upd   = ctl_wr && bus.wdata[BIT_WR_UPD];
    assign rd_upd   = ctl_wr && bus.wdata[BIT_RD_UPD];
    // flags a running value outside its legal coding
    assign wday_bad  = !$onehot(cw_q[6:0]) || cw_q[7];
    assign month_bad = !month_ok(cm_q, bcd_q);
    assign year_bad  = !year_ok(cy_q, bcd_q);

    always_comb begin
        hw_d    = hw_q;
        hm_d    = hm_q;
        hy_d    = hy_q;
        rw_d    = rw_q;
        rm_d    = rm_q;
        ry_d    = ry_q;
        cw_d    = cw_q;
        cm_d    = cm_q;
        cy_d    = cy_q;
        bcd_d   = bcd_q;
        rdata_d = 8'h00;
        wrap_y  = 1'b0;
        // day tick advances the running counters
        // a tick in the same write as a format change counts in the old format
        if (day_tick) begin
            if (cw_q[6:0] == WEEKDAY_LAST) begin
                cw_d = {1'b0, WEEKDAY_FIRST};
            end else begin
                cw_d = {1'b0, cw_q[5:0], 1'b0};
            end
            if (cm_q == (bcd_q ? MONTH_LAST_BCD : MONTH_LAST_BIN)) begin
                cm_d   = RST_MONTH;
                wrap_y = 1'b1;
            end else begin
                cm_d = inc(cm_q, bcd_q);
            end
            if (wrap_y) begin
                if (cy_q == (bcd_q ? YEAR_LAST_BCD : YEAR_LAST_BIN)) begin
                    cy_d = RST_YEAR;
                end else begin
                    cy_d = inc(cy_q, bcd_q);
                end
            end
        end
        // a write-update overrides a tick in the same write
        if (wr_upd) begin
            cw_d = hw_q;
            cm_d = hm_q;
            cy_d = hy_q;
        end
        // the snapshot takes the running value from before this write
        if (rd_upd) begin
            rw_d = cw_q;
            rm_d = cm_q;
            ry_d = cy_q;
        end
        if (ctl_wr) begin
            bcd_d = bus.wdata[BIT_BCD];
        end
        if (bus.wr) begin
            unique case (bus.addr)
                OFS_WEEKDAY: hw_d = {1'b0, bus.wdata[6:0]};
                OFS_MONTH:   hm_d = {3'h0, bus.wdata[4:0]};
                OFS_YEAR:    hy_d = bus.wdata;
                default: ;
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_WEEKDAY: rdata_d = rw_q;
                OFS_MONTH:   rdata_d = rm_q;
                OFS_YEAR:    rdata_d = ry_q;
                OFS_UPDATE:  rdata_d = {5'h00, bcd_q, 2'h0};
                // unmapped addresses read as zero
                default:     rdata_d = 8'h00;
            endcase
        end
        err_d = wday_bad || month_bad || year_bad;
    end

    // clk_en low freezes every register, the read data included
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hw_q    <= RST_WEEKDAY;
            hm_q    <= RST_MONTH;
            hy_q    <= RST_YEAR;
            rw_q    <= RST_WEEKDAY;
            rm_q    <= RST_MONTH;
            ry_q    <= RST_YEAR;
            cw_q    <= RST_WEEKDAY;
            cm_q    <= RST_MONTH;
            cy_q    <= RST_YEAR;
            bcd_q   <= 1'b0;
            rdata_q <= 8'h00;
            err_q   <= 1'b0;
        end else if (clk_en) begin
            hw_q    <= hw_d;
            hm_q    <= hm_d;
            hy_q    <= hy_d;
            rw_q    <= rw_d;
            rm_q    <= rm_d;
            ry_q    <= ry_d;
            cw_q    <= cw_d;
            cm_q    <= cm_d;
            cy_q    <= cy_d;
            bcd_q   <= bcd_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end
endmodule

// file: hdl/rcd_host.sv
// rcd_host: controller that turns software orders into register port cycles.
// assumes: software writes address/data, then a command; one access at a time.
`timescale 1ns/1ps
module rcd_host (
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    input  wire logic                      clk_en,
    rcd_reg_if.host                        bus,
    input  wire logic [rcd_pkg::ADDR_W-1:0] sw_addr,
    input  wire logic [7:0]                sw_wdata,
    input  wire logic                      sw_wr,
    input  wire logic                      sw_rd,
    output logic      [7:0]                sw_rdata
);
    import rcd_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_WAIT} rcd_hstate_t;
    rcd_hstate_t st_q, st_d;
    logic [7:0] tgt_q, tgt_d, dat_q, dat_d, rbk_q, rbk_d, srd_q, srd_d;
    logic       wr_q, wr_d, rd_q, rd_d, busy_q, busy_d;

    assign bus.addr  = tgt_q;
    assign bus.wdata = dat_q;
    assign bus.wr    = wr_q;
    assign bus.rd    = rd_q;
    assign sw_rdata  = srd_q;

    always_comb begin
        st_d   = st_q;
        tgt_d  = tgt_q;
        dat_d  = dat_q;
        rbk_d  = rbk_q;
        wr_d   = 1'b0;
        rd_d   = 1'b0;
        busy_d = busy_q;
        srd_d  = 8'h00;
        if (sw_wr && st_q == S_IDLE) begin
            unique case (sw_addr)
                HOFS_ADDR:  tgt_d = sw_wdata;
                HOFS_WDATA: dat_d = sw_wdata;
                HOFS_CMD: begin
                    // one device access per command; a command written while in S_WAIT is dropped
                    if (sw_wdata[CMD_WRITE]) begin
                        wr_d = 1'b1;
                    end else if (sw_wdata[CMD_READ]) begin
                        rd_d   = 1'b1;
                        busy_d = 1'b1;
                        st_d   = S_WAIT;
                    end
                end
                default: ;
            endcase
        end
        if (st_q == S_WAIT && !rd_q) begin
            rbk_d  = bus.rdata;
            busy_d = 1'b0;
            st_d   = S_IDLE;
        end
        if (sw_rd) begin
            unique case (sw_addr)
                HOFS_ADDR:   srd_d = tgt_q;
                HOFS_WDATA:  srd_d = dat_q;
                HOFS_RDATA:  srd_d = rbk_q;
                HOFS_STATUS: srd_d = {7'h00, busy_q};
                default:     srd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q   <= S_IDLE;
            tgt_q  <= 8'h00;
            dat_q  <= 8'h00;
            rbk_q  <= 8'h00;
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            busy_q <= 1'b0;
            srd_q  <= 8'h00;
        end else if (clk_en) begin
            st_q   <= st_d;
            tgt_q  <= tgt_d;
            dat_q  <= dat_d;
            rbk_q  <= rbk_d;
            wr_q   <= wr_d;
            rd_q   <= rd_d;
            busy_q <= busy_d;
            srd_q  <= srd_d;
        end
    end
endmodule

// file: hdl/rcd_pkg.sv
// rcd_pkg: shared constants for the calendar date block (weekday, month, year).
// assumes: both ends import it; one clock, async active-high reset.
package rcd_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam logic [7:0]  OFS_WEEKDAY    = 8'h0A;
    localparam logic [7:0]  OFS_MONTH      = 8'h0B;
    localparam logic [7:0]  OFS_YEAR       = 8'h0C;
    // device-side control register; bit positions below
    localparam logic [7:0]  OFS_UPDATE     = 8'h10;
    localparam int          BIT_WR_UPD     = 0;
    localparam int          BIT_RD_UPD     = 1;
    localparam int          BIT_BCD        = 2;
    localparam int          BIT_DAY_TICK   = 3;
    // host-side registers
    localparam logic [7:0]  HOFS_ADDR      = 8'h00;
    localparam logic [7:0]  HOFS_WDATA     = 8'h01;
    localparam logic [7:0]  HOFS_CMD       = 8'h02;
    localparam logic [7:0]  HOFS_RDATA     = 8'h03;
    localparam logic [7:0]  HOFS_STATUS    = 8'h04;
    localparam int          CMD_WRITE      = 0;
    localparam int          CMD_READ       = 1;
    localparam logic [7:0]  RST_WEEKDAY    = 8'h01;
    localparam logic [7:0]  RST_MONTH      = 8'h01;
    localparam logic [7:0]  RST_YEAR       = 8'h00;
    localparam logic [6:0]  WEEKDAY_FIRST  = 7'h01;
    localparam logic [6:0]  WEEKDAY_LAST   = 7'h40;
    localparam logic [7:0]  MONTH_LAST_BIN = 8'h0C;
    localparam logic [7:0]  MONTH_LAST_BCD = 8'h12;
    localparam logic [7:0]  YEAR_LAST_BIN  = 8'h63;
    localparam logic [7:0]  YEAR_LAST_BCD  = 8'h99;
    localparam logic [7:0]  FIELD_ERR      = 8'hFF;
endpackage

// file: hdl/rcd_reg_if.sv
// rcd_reg_if: register port between host controller and calendar device.
// assumes: both ends on the same clock; read data valid one cycle after rd.
`timescale 1ns/1ps
interface rcd_reg_if;
    import rcd_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    modport host   (output addr, output wdata, output wr, output rd, input rdata);
    modport device (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// file: tb/rcd_chk.sv
// rcd_chk: watches the register port between host controller and device.
// assumes: one clock, sys_rst async high; format bit tracked from control writes.
`timescale 1ns/1ps
module rcd_chk (
    input wire logic                        clock,
    input wire logic                        sys_rst,
    input wire logic [rcd_pkg::ADDR_W-1:0]  addr,
    input wire logic [rcd_pkg::DATA_W-1:0]  wdata,
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [rcd_pkg::DATA_W-1:0]  rdata
);
    import rcd_pkg::*;
    logic fmt_q;
    logic fmt_d;
    logic rd_m;
    logic rd_y;
    // every control write restores the format bit, so only that write is tracked
    always_comb fmt_d = (wr && addr == OFS_UPDATE) ? wdata[BIT_BCD] : fmt_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fmt_q <= 1'b0;
        end else begin
            fmt_q <= fmt_d;
        end
    end
    assign rd_m = rd && addr == OFS_MONTH;
    assign rd_y = rd && addr == OFS_YEAR;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_idle_zero; !$past(rd) |-> rdata == 8'h00; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("rdata not idle");
    property p_wday; rd && addr == OFS_WEEKDAY |=> $onehot(rdata[6:0]) && !rdata[7]; endproperty
    a_wday: assert property (p_wday) else $error("weekday not one-hot");
    property p_mon_bin; rd_m && !fmt_q |=> rdata inside {[8'h01:8'h0C]}; endproperty
    a_mon_bin: assert property (p_mon_bin) else $error("binary month out of range");
    property p_mon_dig; rd_m && fmt_q |=> rdata[7:5] == 3'h0 && rdata[3:0] <= 4'h9; endproperty
    a_mon_dig: assert property (p_mon_dig) else $error("bcd month digit bad");
    property p_mon_bcd; rd_m && fmt_q |=> rdata != 8'h00 && rdata <= 8'h12; endproperty
    a_mon_bcd: assert property (p_mon_bcd) else $error("bcd month out of range");
    property p_yr_bin; rd_y && !fmt_q |=> rdata <= 8'h63; endproperty
    a_yr_bin: assert property (p_yr_bin) else $error("binary year out of range");
    property p_yr_bcd; rd_y && fmt_q |=> rdata[7:4] <= 4'h9 && rdata[3:0] <= 4'h9; endproperty
    a_yr_bcd: assert property (p_yr_bcd) else $error("bcd year digit bad");
    property p_fmt; rd && addr == OFS_UPDATE |=> rdata == {5'h00, fmt_q, 2'h0}; endproperty
    a_fmt: assert property (p_fmt) else $error("format bit readback wrong");
endmodule

// file: tb/tb.sv
// tb: host controller and calendar device joined by the register port.
// assumes: clk_en held high; software port driven here, checker beside the bus.
`timescale 1ns/1ps
module tb;
    import rcd_pkg::*;
    logic       clock, sys_rst, clk_en, sw_wr, sw_rd, bcd_mode, field_error;
    logic [7:0] sw_addr, sw_wdata, sw_rdata, v;
    int         n_errors, n_compared, cycles;
    rcd_reg_if bus ();
    rcd_host rcd_host_i (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus.host),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata));
    rcd_device rcd_device_i (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus(bus.device), .bcd_mode(bcd_mode), .field_error(field_error));
    rcd_chk rcd_chk_i (.clock(clock), .sys_rst(sys_rst), .addr(bus.addr), .wdata(bus.wdata),
        .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one software strobe; read data are taken in the cycle after it
    task automatic sw_op(input logic [7:0] a, input logic [7:0] d, input logic r);
        @(posedge clock);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= !r;
        sw_rd <= r;
        @(posedge clock);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask
    task automatic dev_op(input logic [7:0] a, input logic [7:0] d, input logic r);
        sw_op(HOFS_ADDR, a, 1'b0);
        sw_op(HOFS_WDATA, d, 1'b0);
        sw_op(HOFS_CMD, 8'h01 << (r ? CMD_READ : CMD_WRITE), 1'b0);
        v = 8'h01;
        for (int i = 0; i < 20 && v[0] !== 1'b0; i++) sw_op(HOFS_STATUS, 8'h00, 1'b1);
        check(v, 8'h00);
        if (r) sw_op(HOFS_RDATA, 8'h00, 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dev_op(a, d, 1'b0);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        dev_op(a, 8'h00, 1'b1);
        check(v, exp);
    endtask
    task automatic t_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk(OFS_WEEKDAY, RST_WEEKDAY);
        rd_chk(OFS_MONTH, RST_MONTH);
        rd_chk(OFS_YEAR, RST_YEAR);
        rd_chk(OFS_UPDATE, 8'h00);
        rd_chk(8'h20, 8'h00);
        wr(OFS_UPDATE, 8'h02);
        rd_chk(OFS_WEEKDAY, RST_WEEKDAY);
        rd_chk(OFS_MONTH, RST_MONTH);
        rd_chk(OFS_YEAR, RST_YEAR);
    endtask
    // an illegal running month raises the flag until a legal one is loaded
    task automatic t_field();
        wr(OFS_WEEKDAY, 8'h20);
        wr(OFS_MONTH, 8'h0D);
        wr(OFS_YEAR, 8'h45);
        wr(OFS_UPDATE, 8'h01);
        check({7'h00, field_error}, 8'h01);
        wr(OFS_MONTH, 8'h0C);
        wr(OFS_UPDATE, 8'h01);
        check({7'h00, field_error}, 8'h00);
        check({7'h00, bcd_mode}, 8'h00);
    endtask
    task automatic t_buffer();
        wr(OFS_MONTH, 8'h05);
        wr(OFS_WEEKDAY, 8'h08);
        wr(OFS_YEAR, 8'h2A);
        wr(OFS_UPDATE, 8'h02);
        rd_chk(OFS_MONTH, 8'h01);
        wr(OFS_UPDATE, 8'h01);
        rd_chk(OFS_MONTH, 8'h01);
        wr(OFS_UPDATE, 8'h02);
        rd_chk(OFS_MONTH, 8'h05);
        rd_chk(OFS_WEEKDAY, 8'h08);
        rd_chk(OFS_YEAR, 8'h2A);
    endtask
    // snapshot and day tick in one write: the snapshot sees the value before the tick
    task automatic t_wrap();
        wr(OFS_WEEKDAY, 8'h40);
        wr(OFS_MONTH, 8'h0C);
        wr(OFS_YEAR, 8'h63);
        wr(OFS_UPDATE, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_UPDATE, 8'h0A);
            rd_chk(OFS_WEEKDAY, i == 0 ? 8'h40 : 8'h01 << (i - 1));
            rd_chk(OFS_MONTH, i == 0 ? 8'h0C : 8'(i));
            rd_chk(OFS_YEAR, i == 0 ? 8'h63 : 8'h00);
        end
    endtask
    task automatic t_bcd(input logic [7:0] m, input logic [7:0] y,
                         input logic [7:0] em, input logic [7:0] ey);
        wr(OFS_MONTH, m);
        wr(OFS_YEAR, y);
        wr(OFS_UPDATE, 8'h05);
        wr(OFS_UPDATE, 8'h0C);
        wr(OFS_UPDATE, 8'h06);
        rd_chk(OFS_MONTH, em);
        rd_chk(OFS_YEAR, ey);
        rd_chk(OFS_UPDATE, 8'h04);
        check({7'h00, bcd_mode}, 8'h01);
        check({7'h00, field_error}, 8'h00);
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        {sys_rst, clk_en, sw_wr, sw_rd, sw_addr, sw_wdata} = {2'h3, 18'h00000};
        {n_errors, n_compared, cycles} = '0;
        t_reset();
        t_buffer();
        t_wrap();
        t_bcd(8'h09, 8'h19, 8'h10, 8'h19);
        t_bcd(8'h12, 8'h99, 8'h01, 8'h00);
        t_field();
        t_reset();
        wrap_up();
    end
    // ceiling well above the fewer than one thousand cycles the sequence needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            wrap_up();
        end
    end
endmodule
